//--- logic/pll_ctrl_pkg.sv
package pll_ctrl_pkg;
  localparam int ADDR_W          = 7;
  localparam int DATA_W          = 16;
  localparam int DIV_MAX         = 128;
  localparam int DIV_MIN         = 1;
  localparam int DIV_W           = 8;
  localparam int CFG_DEPTH       = 128;
  // Configuration locations holding the two divisors
  localparam logic [6:0] ADDR_DIV_A = 7'h08;
  localparam logic [6:0] ADDR_DIV_B = 7'h0a;
  localparam logic [15:0] DIV_RESET = 16'h0001;
  // Lock acquisition: reference edges in window before lock
  localparam int LOCK_EDGES      = 8;
  // Reference clock considered stopped after this many ns
  localparam int REF_STOP_NS     = 400;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int REF_STOP_CYC    = REF_STOP_NS / CLK_PERIOD_NS;
  // Phase window: allowed deviation of reference period, in sys cycles
  localparam int PHASE_TOL       = 1;
  // Shadow commit delay, in sys cycles
  localparam int COMMIT_CYC      = 2;
  // Reconfig clock made by the controller: sys cycles per half period
  localparam int RCLK_HALF       = 4;
  typedef enum logic [1:0] {
    P_IDLE   = 2'b00,
    P_ACCESS = 2'b01,
    P_COMMIT = 2'b11,
    P_DONE   = 2'b10
  } port_state_e;
endpackage : pll_ctrl_pkg

//--- logic/pll_link_if.sv
`timescale 1ns/100ps
interface pll_link_if;
  logic        rstPll;
  logic        powerDownIn;
  logic        phyClockEnable;
  logic        reconfClock;
  logic [6:0]  reconfAddress;
  logic [15:0] reconfWriteData;
  logic        reconfWriteEnable;
  logic        reconfAccessStrobe;
  logic [15:0] reconfReadData;
  logic        reconfReady;
  logic        lockIndicator;
  modport device (
    input  rstPll, powerDownIn, phyClockEnable, reconfClock, reconfAddress,
           reconfWriteData, reconfWriteEnable, reconfAccessStrobe,
    output reconfReadData, reconfReady, lockIndicator
  );
  modport controller (
    output rstPll, powerDownIn, phyClockEnable, reconfClock, reconfAddress,
           reconfWriteData, reconfWriteEnable, reconfAccessStrobe,
    input  reconfReadData, reconfReady, lockIndicator
  );
endinterface : pll_link_if

//--- logic/sync_2ff.sv
`timescale 1ns/100ps
module sync_2ff (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : sync_2ff

//--- logic/pll_device.sv
`timescale 1ns/100ps
module pll_device #(
  parameter int DIV_INIT_A = 1,
  parameter int DIV_INIT_B = 1
) (
  input  wire logic      clk_sys,
  input  wire logic      srst,
  input  wire logic      ref_clock_in,
  pll_link_if.device     link,
  output logic           gen_clock_out_a,
  output logic           gen_clock_out_b,
  output logic           gen_clock_out_a_inv,
  output logic           gen_clock_out_b_inv,
  output logic           phy_clock_out,
  output logic           feedback_clock_out
);
  initial
  begin
    if (DIV_INIT_A < pll_ctrl_pkg::DIV_MIN || DIV_INIT_A > pll_ctrl_pkg::DIV_MAX
        || DIV_INIT_B < pll_ctrl_pkg::DIV_MIN
        || DIV_INIT_B > pll_ctrl_pkg::DIV_MAX)
      $error("divisor default out of range");
  end

  logic        refS, rstS, pdS, phyEnS, rclkS;
  logic        refPrev, rclkPrev;
  logic        halted;
  logic        running;
  logic [15:0] refPeriod, lastPeriod, sinceEdge;
  logic [3:0]  goodEdges;
  logic        lockIndicator;
  logic        phyGate;
  logic [7:0]  cntA, cntB;
  logic [7:0]  divA, divB;
  logic [15:0] cfgMem [pll_ctrl_pkg::CFG_DEPTH];
  logic [15:0] readData;
  logic        ready;
  logic [6:0]  shadowAddr;
  logic [15:0] shadowData;
  logic [1:0]  commitCnt;
  pll_ctrl_pkg::port_state_e portState, next_portState;

  sync_2ff uRef (.clk_sys(clk_sys), .srst(srst), .din(ref_clock_in),
                 .dout(refS));
  sync_2ff uRst (.clk_sys(clk_sys), .srst(srst), .din(link.rstPll),
                 .dout(rstS));
  sync_2ff uPd (.clk_sys(clk_sys), .srst(srst), .din(link.powerDownIn),
                .dout(pdS));
  sync_2ff uPhy (.clk_sys(clk_sys), .srst(srst), .din(link.phyClockEnable),
                 .dout(phyEnS));
  sync_2ff uRclk (.clk_sys(clk_sys), .srst(srst), .din(link.reconfClock),
                  .dout(rclkS));

  wire refRise  = refS & ~refPrev;
  wire rclkRise = rclkS & ~rclkPrev;
  wire haltNow  = link.rstPll | pdS;
  wire refStop  = (sinceEdge >= 16'(pll_ctrl_pkg::REF_STOP_CYC));
  wire periodOk = (refPeriod + 16'(pll_ctrl_pkg::PHASE_TOL) >= lastPeriod)
                  && (refPeriod <= lastPeriod + 16'(pll_ctrl_pkg::PHASE_TOL));

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      refPrev  <= 1'b0;
      rclkPrev <= 1'b0;
      halted   <= 1'b1;
    end
    else
    begin
      refPrev  <= refS;
      rclkPrev <= rclkS;
      halted   <= rstS | pdS;
    end
  end

  assign running = ~halted & ~haltNow;

  always_ff @(posedge clk_sys)
  begin
    if (srst || !running)
    begin
      sinceEdge     <= '0;
      refPeriod     <= '0;
      lastPeriod    <= '0;
      goodEdges     <= '0;
      lockIndicator <= 1'b0;
    end
    else if (refRise)
    begin
      sinceEdge  <= 16'h0001;
      refPeriod  <= sinceEdge;
      lastPeriod <= refPeriod;
      if (!periodOk && goodEdges != 4'h0)
      begin
        goodEdges     <= '0;
        lockIndicator <= 1'b0;
      end
      else if (goodEdges == 4'(pll_ctrl_pkg::LOCK_EDGES))
        lockIndicator <= 1'b1;
      else
        goodEdges <= goodEdges + 4'h1;
    end
    else if (refStop)
    begin
      goodEdges     <= '0;
      lockIndicator <= 1'b0;
    end
    else
      sinceEdge <= sinceEdge + 16'h0001;
  end
  assign link.lockIndicator = lockIndicator & ~haltNow;

  always_ff @(posedge clk_sys)
  begin
    if (srst || !running)
    begin
      cntA            <= '0;
      cntB            <= '0;
      gen_clock_out_a <= 1'b0;
      gen_clock_out_b <= 1'b0;
      feedback_clock_out <= 1'b0;
    end
    else
    begin
      feedback_clock_out <= ~feedback_clock_out;
      if (cntA + 8'h01 >= divA)
      begin
        cntA            <= '0;
        gen_clock_out_a <= ~gen_clock_out_a;
      end
      else
        cntA <= cntA + 8'h01;
      if (cntB + 8'h01 >= divB)
      begin
        cntB            <= '0;
        gen_clock_out_b <= ~gen_clock_out_b;
      end
      else
        cntB <= cntB + 8'h01;
    end
  end

  assign gen_clock_out_a_inv = ~gen_clock_out_a;
  assign gen_clock_out_b_inv = ~gen_clock_out_b;

  // gate changes while reference low or clears at once on halt, first edge on ref rise
  always_ff @(posedge clk_sys)
  begin
    if (srst || !running)
      phyGate <= 1'b0;
    else if (!refS)
      phyGate <= phyEnS & lockIndicator;
  end
  assign phy_clock_out = phyGate & refS;

  wire [7:0] cfgDivA = cfgMem[pll_ctrl_pkg::ADDR_DIV_A][7:0];
  wire [7:0] cfgDivB = cfgMem[pll_ctrl_pkg::ADDR_DIV_B][7:0];
  assign divA = (cfgDivA == 8'h00 || cfgDivA > 8'h80) ? 8'h01 : cfgDivA;
  assign divB = (cfgDivB == 8'h00 || cfgDivB > 8'h80) ? 8'h01 : cfgDivB;

  wire takeAccess = rclkRise & link.reconfAccessStrobe;
  wire isRead     = ~link.reconfWriteEnable;

  always_comb
  begin
    next_portState = portState;
    case (portState)
      pll_ctrl_pkg::P_IDLE:
        if (takeAccess)
          next_portState = isRead ? pll_ctrl_pkg::P_DONE
                                  : pll_ctrl_pkg::P_COMMIT;
      pll_ctrl_pkg::P_COMMIT:
        if (commitCnt == 2'(pll_ctrl_pkg::COMMIT_CYC - 1))
          next_portState = pll_ctrl_pkg::P_DONE;
      pll_ctrl_pkg::P_DONE:
        if (rclkRise)
          next_portState = pll_ctrl_pkg::P_ACCESS;
      pll_ctrl_pkg::P_ACCESS:
        if (rclkRise)
          next_portState = pll_ctrl_pkg::P_IDLE;
      default:
        next_portState = pll_ctrl_pkg::P_IDLE;
    endcase
  end

  // ready for one port clock period
  assign ready = (portState == pll_ctrl_pkg::P_ACCESS);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      portState  <= pll_ctrl_pkg::P_IDLE;
      commitCnt  <= '0;
      shadowAddr <= '0;
      shadowData <= '0;
      readData   <= '0;
    end
    else
    begin
      portState <= next_portState;
      if (portState == pll_ctrl_pkg::P_IDLE && takeAccess)
      begin
        commitCnt <= '0;
        shadowAddr <= link.reconfAddress;
        shadowData <= link.reconfWriteData;
        if (isRead)
          readData <= cfgMem[link.reconfAddress];
      end
      else if (portState == pll_ctrl_pkg::P_COMMIT)
        commitCnt <= commitCnt + 2'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < pll_ctrl_pkg::CFG_DEPTH; i++)
        cfgMem[i] <= '0;
      cfgMem[pll_ctrl_pkg::ADDR_DIV_A] <= 16'(DIV_INIT_A);
      cfgMem[pll_ctrl_pkg::ADDR_DIV_B] <= 16'(DIV_INIT_B);
    end
    else if (portState == pll_ctrl_pkg::P_COMMIT
             && next_portState == pll_ctrl_pkg::P_DONE)
      cfgMem[shadowAddr] <= shadowData;
  end

  assign link.reconfReadData = readData;
  assign link.reconfReady    = ready;
endmodule : pll_device

//--- logic/pll_controller.sv
`timescale 1ns/100ps
module pll_controller (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  pll_link_if.controller   link,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [6:0]  reqAddress,
  input  wire logic [15:0] reqData,
  output logic             reqReady,
  output logic             rspValid,
  output logic [15:0]      rspData,
  input  wire logic        refChanged,
  input  wire logic        powerDown,
  input  wire logic        phyEnable,
  output logic             lock_indicator
);
  logic        rclk;
  logic [2:0]  halfCnt;
  logic        busy, strobe, we;
  logic        strobeOld;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic        lockS, lockPrev, rstReq;
  logic        rdyS, rdyPrev;
  sync_2ff uLock (.clk_sys(clk_sys), .srst(srst), .din(link.lockIndicator),
                  .dout(lockS));
  sync_2ff uRdy (.clk_sys(clk_sys), .srst(srst), .din(link.reconfReady),
                 .dout(rdyS));
  wire rclkFall = (halfCnt == 3'(pll_ctrl_pkg::RCLK_HALF - 1)) & rclk;
  wire rdyRise  = rdyS & ~rdyPrev;
  // one access outstanding
  // Also wait for the last answer to end, else the port would be busy
  assign reqReady = ~busy & ~strobe & ~rdyS;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rclk <= 1'b0; halfCnt <= '0; busy <= 1'b0; strobe <= 1'b0;
      we <= 1'b0; addr <= '0; wdata <= '0; rdyPrev <= 1'b0;
      lockPrev <= 1'b0; rstReq <= 1'b1; rspValid <= 1'b0; rspData <= '0;
      strobeOld <= 1'b0;
    end
    else
    begin
      rdyPrev  <= rdyS;
      lockPrev <= lockS;
      strobeOld <= strobe;
      rspValid <= 1'b0;
      if (halfCnt == 3'(pll_ctrl_pkg::RCLK_HALF - 1))
      begin
        halfCnt <= '0;
        rclk    <= ~rclk;
      end
      else
        halfCnt <= halfCnt + 3'h1;
      // reset on reference change or lock loss
      rstReq <= refChanged | (lockPrev & ~lockS);
      if (reqValid && reqReady)
      begin
        busy <= 1'b1; strobe <= 1'b1; we <= reqWrite;
        addr <= reqAddress; wdata <= reqWrite ? reqData : 16'h0000;
      end
      // Strobe raised just before a fall has not met a port clock rise yet
      else if (strobe && strobeOld && rclkFall)
      begin
        strobe <= 1'b0; we <= 1'b0; addr <= '0; wdata <= '0;
      end
      if (busy && !strobe && rdyRise)
      begin
        busy     <= 1'b0;
        rspValid <= 1'b1;
        rspData  <= link.reconfReadData;
      end
    end
  end
  assign link.reconfClock        = rclk;
  assign link.reconfAccessStrobe = strobe;
  assign link.reconfWriteEnable  = we;
  assign link.reconfAddress      = addr;
  assign link.reconfWriteData    = wdata;
  assign link.rstPll             = rstReq;
  assign link.powerDownIn        = powerDown;
  assign link.phyClockEnable     = phyEnable;
  assign lock_indicator                  = lockS;
endmodule : pll_controller

//--- tb/pll_link_checker.sv
`timescale 1ns/100ps
module pll_link_checker (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        rstPll,
  input wire logic        powerDownIn,
  input wire logic [6:0]  reconfAddress,
  input wire logic [15:0] reconfWriteData,
  input wire logic        reconfWriteEnable,
  input wire logic        reconfAccessStrobe,
  input wire logic [15:0] reconfReadData,
  input wire logic        reconfReady,
  input wire logic        lockIndicator
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Set by a strobe, cleared when its ready answer arrives
  logic pend;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pend <= 1'b0;
    else if ($rose(reconfReady))
      pend <= 1'b0;
    else if (reconfAccessStrobe)
      pend <= 1'b1;
  end
  a_rst_drops_lock: assert property (
    rstPll |-> !lockIndicator) else $error("lock high during reset");
  a_pwrdn_no_lock: assert property (
    powerDownIn [*4] |-> !lockIndicator) else $error("lock in power-down");
  a_ready_follows: assert property (
    $rose(reconfAccessStrobe) |-> ##[1:40] reconfReady)
    else $error("strobe not answered");
  a_ready_cause: assert property (
    $rose(reconfReady) |-> pend) else $error("ready without strobe");
  a_ready_width: assert property (
    $rose(reconfReady) |-> reconfReady [*6]) else $error("ready too short");
  a_rdata_held: assert property (
    $changed(reconfReadData) |-> pend)
    else $error("read data moved outside an answer");
  a_request_stable: assert property (
    reconfAccessStrobe && $past(reconfAccessStrobe) |->
    $stable({reconfAddress, reconfWriteData, reconfWriteEnable}))
    else $error("request changed under strobe");
  a_one_outstanding: assert property (
    $rose(reconfAccessStrobe) |-> !pend) else $error("second access early");
  a_reset_on_unlock: assert property (
    $fell(lockIndicator) && !$past(rstPll) && !powerDownIn
    |-> ##[0:30] rstPll) else $error("no reset after lock loss");
endmodule : pll_link_checker

//--- tb/pll_control_and_reconfig_port_tb.sv
`timescale 1ns/100ps
module pll_control_and_reconfig_port_tb;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        refClk = 1'b0;
  logic        refRun = 1'b1;
  int          refHalf = 40;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [6:0]  reqAddress = 7'h00;
  logic [15:0] reqData = 16'h0000;
  logic        refChanged = 1'b0;
  logic        powerDown = 1'b0;
  logic        phyEnable = 1'b0;
  logic        reqReady, rspValid, lock_indicator, genA, genB, genAInv, genBInv;
  logic        phyOut, selB = 1'b0;
  logic [15:0] rspData, dv;
  logic [16:0] e;
  logic [15:0] mem [128];
  logic [16:0] expq [$];
  logic [6:0]  ad;
  int          phyCnt = 0;
  int          err_total = 0;
  int          samples_checked = 0;
  wire         g = selB ? genB : genA;
  wire         gi = selB ? genBInv : genAInv;

  always #5 clk_sys = ~clk_sys;
  always #(refHalf) if (refRun) refClk = ~refClk;
  always @(posedge phyOut) phyCnt++;

  pll_link_if pll_link_if_i ();
  pll_device pll_device_i (
    .clk_sys(clk_sys), .srst(srst), .ref_clock_in(refClk),
    .link(pll_link_if_i), .gen_clock_out_a(genA), .gen_clock_out_b(genB),
    .gen_clock_out_a_inv(genAInv), .gen_clock_out_b_inv(genBInv),
    .phy_clock_out(phyOut), .feedback_clock_out()
  );
  pll_controller pll_controller_i (
    .clk_sys(clk_sys), .srst(srst), .link(pll_link_if_i),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddress(reqAddress),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .refChanged(refChanged), .powerDown(powerDown),
    .phyEnable(phyEnable), .lock_indicator(lock_indicator)
  );
  pll_link_checker pll_link_checker_i (
    .clk_sys(clk_sys), .srst(srst), .rstPll(pll_link_if_i.rstPll),
    .powerDownIn(pll_link_if_i.powerDownIn),
    .reconfAddress(pll_link_if_i.reconfAddress),
    .reconfWriteData(pll_link_if_i.reconfWriteData),
    .reconfWriteEnable(pll_link_if_i.reconfWriteEnable),
    .reconfAccessStrobe(pll_link_if_i.reconfAccessStrobe),
    .reconfReadData(pll_link_if_i.reconfReadData),
    .reconfReady(pll_link_if_i.reconfReady),
    .lockIndicator(pll_link_if_i.lockIndicator)
  );

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock_indicator !== v && n < 900)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("lock_indicator", lock_indicator, v);
    #1;
  endtask : wait_lock

  // Queue the expected answer, then hold the request until taken
  task automatic access(input logic wr, input logic [6:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    expq.push_back({~wr, wr ? d : mem[a]});
    if (wr)
      mem[a] = d;
    tick(1);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddress = a;
    reqData = d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (reqReady !== 1'b1 && n < 100);
    #1;
    reqValid = 1'b0;
    while (expq.size() > 0 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    #1;
  endtask : access

  task automatic period(input logic s, input int div);
    realtime t;
    selB = s;
    repeat (3) @(posedge g);
    t = $realtime;
    @(posedge g);
    check("period", 16'(int'(($realtime - t) / 10)), 16'(2 * div));
    #1;
    check("inverse", gi, 16'h0000);
  endtask : period

  always @(posedge clk_sys)
    if (rspValid === 1'b1)
    begin
      e = (expq.size() > 0) ? expq.pop_front() : 17'h1dead;
      if (e[16])
        check("rspData", rspData, e[15:0]);
    end

  initial
  begin
    #600000;
    err_total++;
    results();
  end

  initial
  begin
    void'($urandom(43994));
    tick(5);
    srst = 1'b0;
    wait_lock(1'b1);
    period(1'b0, 1);
    for (int i = 0; i < 4; i++)
    begin
      dv = (i < 2) ? 16'h0080 : 16'($urandom_range(128, 1));
      ad = i[0] ? pll_ctrl_pkg::ADDR_DIV_B : pll_ctrl_pkg::ADDR_DIV_A;
      access(1'b1, ad, dv);
      access(1'b0, ad, 16'($urandom));
      period(i[0], int'(dv));
    end
    for (int i = 0; i < 6; i++)
    begin
      ad = 7'($urandom) & 7'h77;
      access(1'b1, ad, 16'($urandom));
      access(1'b0, ad, 16'($urandom));
      access(1'b0, ad, 16'($urandom));
    end
    powerDown = 1'b1;
    wait_lock(1'b0);
    powerDown = 1'b0;
    refChanged = 1'b1;
    tick(1);
    refChanged = 1'b0;
    wait_lock(1'b1);
    refRun = 1'b0;
    wait_lock(1'b0);
    refRun = 1'b1;
    wait_lock(1'b1);
    refHalf = 30;
    wait_lock(1'b0);
    refChanged = 1'b1;
    tick(1);
    refChanged = 1'b0;
    wait_lock(1'b1);
    phyEnable = 1'b1;
    tick(100);
    phyCnt = 0;
    tick(100);
    check("phyRun", 16'(phyCnt > 0), 16'h0001);
    phyEnable = 1'b0;
    tick(100);
    phyCnt = 0;
    tick(100);
    check("phyStop", 16'(phyCnt), 16'h0000);
    results();
  end
endmodule : pll_control_and_reconfig_port_tb
